/* File: rtl/wcrc_pkg.sv */
package wcrc_pkg;
   // ------------------------------------------------------------
   // mode register 0 burst field
   // ------------------------------------------------------------
   localparam logic [1:0] BURST_BL8 = 2'h0;
   localparam logic [1:0] BURST_OTF = 2'h1;
   localparam logic [1:0] BURST_BC4 = 2'h2;

   // ------------------------------------------------------------
   // register map (word index on the plain port)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_ERRCNT = 4'h3;
   localparam logic [3:0] REG_WRCNT = 4'h4;
   localparam logic [3:0] REG_ACCEPT = 4'h5;

   // ctrl field positions
   localparam int CTRL_BURST_LO = 0;
   localparam int CTRL_CRC_EN = 2;
   localparam int CTRL_PRE2 = 3;
   localparam int CTRL_DM_EN = 4;
   localparam int CTRL_CWL_LO = 8;
   localparam int CTRL_CWL_W = 5;
   localparam int CTRL_RESYNC = 16;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0900;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int BEATS_BL8 = 8;
   localparam int BEATS_BC4 = 4;
   localparam int BEATS_CRC = 2;
   localparam int CONSEC_GAP = 5;
   localparam int STROBE_WINDOW = 6;
   localparam int CWL_FORBID = 9;
   localparam logic [7:0] CRC_POLY = 8'h07;

   typedef enum logic [1:0] {
      LAT_IDLE,
      LAT_WAIT,
      LAT_BURST
   } lat_state_t;
endpackage : wcrc_pkg

/* File: rtl/wcrc_calc.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// running crc-8 over one data beat
// ------------------------------------------------------------
module wcrc_calc #(
   parameter int W = 8
) (
   input wire logic [7:0] crc_i,
   input wire logic [W-1:0] data_i,
   output logic [7:0] crc_o
);
   always_comb begin
      logic [7:0] c;
      c = crc_i;
      for (int i = W - 1; i >= 0; i--) begin
         if (c[7] ^ data_i[i]) begin
            c = {c[6:0], 1'b0} ^ wcrc_pkg::CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc_o = c;
   end
endmodule : wcrc_calc

/* File: rtl/wcrc_skid.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-entry buffer, valid/ready both sides
// ------------------------------------------------------------
module wcrc_skid #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_o = cnt_q != '0;
   assign out_data_o = mem_q[rp_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data_i;
         wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : wcrc_skid

/* File: rtl/wcrc_write_path.sv */
`timescale 1ns/1ps
module wcrc_write_path #(
   parameter int DQ_W = 8
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   // command side
   input wire logic WR_CMD_I,
   input wire logic A12_I,
   input wire logic [3:0] BANK_I,
   input wire logic PRE_ALL_IDLE_I,
   // link pins, sampled
   input wire logic DQS_I,
   input wire logic [DQ_W-1:0] DQ_I,
   // register port
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // stored beats
   output logic BEAT_VALID_O,
   input wire logic BEAT_READY_I,
   output logic [DQ_W+3:0] BEAT_DATA_O,
   output logic BURST_DONE_O,
   output logic CRC_ERR_O
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] errcnt_q, errcnt_d;
   logic [15:0] wrcnt_q, wrcnt_d;
   logic cfg_bad;
   logic tainted_q, tainted_d;
   logic [1:0] burst_fld;
   logic crc_en, pre2, dm_en;
   logic [4:0] cwl;

   assign burst_fld = ctrl_q[wcrc_pkg::CTRL_BURST_LO +: 2];
   assign crc_en = ctrl_q[wcrc_pkg::CTRL_CRC_EN];
   assign pre2 = ctrl_q[wcrc_pkg::CTRL_PRE2];
   assign dm_en = ctrl_q[wcrc_pkg::CTRL_DM_EN];
   assign cwl = ctrl_q[wcrc_pkg::CTRL_CWL_LO +: wcrc_pkg::CTRL_CWL_W];

   // ------------------------------------------------------------
   // pin synchronisers: 3 stages, 2nd and 3rd must agree
   // ------------------------------------------------------------
   logic [2:0] dqs_s_q, dqs_s_d;
   logic [DQ_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_s1_d, dq_s2_d, dq_s3_d;
   logic dqs_lvl_q, dqs_lvl_d;
   logic dqs_edge;

   always_comb begin
      dqs_s_d = {dqs_s_q[1:0], DQS_I};
      dq_s1_d = DQ_I;
      dq_s2_d = dq_s1_q;
      dq_s3_d = dq_s2_q;
      dqs_lvl_d = dqs_lvl_q;
      if (dqs_s_q[1] == dqs_s_q[2]) begin
         dqs_lvl_d = dqs_s_q[2];
      end
   end
   // data sampled on each agreed strobe transition
   assign dqs_edge = dqs_lvl_d != dqs_lvl_q;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         dqs_s_q <= '0;
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         dq_s3_q <= '0;
         dqs_lvl_q <= 1'b0;
      end else begin
         dqs_s_q <= dqs_s_d;
         dq_s1_q <= dq_s1_d;
         dq_s2_q <= dq_s2_d;
         dq_s3_q <= dq_s3_d;
         dqs_lvl_q <= dqs_lvl_d;
      end
   end

   // ------------------------------------------------------------
   // write queue: command times to their latency slot
   // ------------------------------------------------------------
   wcrc_pkg::lat_state_t st_q, st_d;
   logic [4:0] lat_q, lat_d;
   logic [3:0] need_q, need_d;
   logic [3:0] beat_q, beat_d;
   logic [3:0] edge_win_q, edge_win_d;
   logic [7:0] crc_q, crc_d, crc_next;
   logic [7:0] rx_crc_q, rx_crc_d;
   logic pend_q, pend_d;
   logic pend_a12_q, pend_a12_d;
   logic [4:0] pend_lat_q, pend_lat_d;
   logic done_q, done_d;
   logic err_q, err_d;
   logic [3:0] cur_bank_q, cur_bank_d;
   logic push_ok;
   logic [3:0] data_beats;
   logic crc_beat;

   // crc beats are checked, never stored
   assign crc_beat = crc_en && beat_q >= need_q - 4'(wcrc_pkg::BEATS_CRC);

   wcrc_calc #(
      .W(DQ_W)
   ) u_crc (
      .crc_i(crc_q),
      .data_i(dq_s3_q),
      .crc_o(crc_next)
   );

   function automatic logic [3:0] beats_of(input logic [1:0] f,
                                           input logic a12);
      logic [3:0] b;
      b = 4'(wcrc_pkg::BEATS_BL8);
      if (f == wcrc_pkg::BURST_BC4) begin
         b = 4'(wcrc_pkg::BEATS_BC4);
      end else if (f == wcrc_pkg::BURST_OTF && !a12) begin
         b = 4'(wcrc_pkg::BEATS_BC4);
      end
      return b;
   endfunction : beats_of

   always_comb begin
      st_d = st_q;
      lat_d = lat_q;
      need_d = need_q;
      beat_d = beat_q;
      edge_win_d = edge_win_q;
      crc_d = crc_q;
      rx_crc_d = rx_crc_q;
      pend_d = pend_q;
      pend_a12_d = pend_a12_q;
      pend_lat_d = pend_lat_q;
      done_d = 1'b0;
      err_d = 1'b0;
      cur_bank_d = cur_bank_q;
      data_beats = beats_of(burst_fld, pend_a12_q);
      // second command while busy waits its own latency
      if (WR_CMD_I && st_q != wcrc_pkg::LAT_IDLE) begin
         pend_d = 1'b1;
         pend_a12_d = A12_I;
         pend_lat_d = cwl;
      end else if (pend_q && pend_lat_q != '0) begin
         pend_lat_d = pend_lat_q - 1'b1;
      end
      unique case (st_q)
         wcrc_pkg::LAT_IDLE: begin
            if (WR_CMD_I) begin
               st_d = wcrc_pkg::LAT_WAIT;
               lat_d = cwl;
               need_d = beats_of(burst_fld, A12_I) +
                        (crc_en ? 4'(wcrc_pkg::BEATS_CRC) : 4'h0);
               cur_bank_d = BANK_I;
            end
         end
         wcrc_pkg::LAT_WAIT: begin
            // every strobe edge from here on carries a beat
            if (lat_q != '0) begin
               lat_d = lat_q - 1'b1;
            end else begin
               st_d = wcrc_pkg::LAT_BURST;
               beat_d = '0;
               crc_d = '0;
               edge_win_d = '0;
            end
         end
         wcrc_pkg::LAT_BURST: begin
            if (dqs_edge && (push_ok || crc_beat)) begin
               beat_d = beat_q + 1'b1;
               if (crc_beat) begin
                  // code in the first crc beat, second one is filler
                  if (beat_q == need_q - 4'(wcrc_pkg::BEATS_CRC)) begin
                     rx_crc_d = dq_s3_q[7:0];
                  end
               end else begin
                  crc_d = crc_next;
               end
               if (beat_q == need_q - 1'b1) begin
                  // recovery reference: after last beat, crc incl.
                  done_d = 1'b1;
                  if (crc_en && rx_crc_d != crc_d) begin
                     err_d = 1'b1;
                  end
                  if (pend_q) begin
                     st_d = wcrc_pkg::LAT_WAIT;
                     lat_d = pend_lat_q;
                     need_d = data_beats +
                              (crc_en ? 4'(wcrc_pkg::BEATS_CRC) : 4'h0);
                     edge_win_d = '0;
                     pend_d = 1'b0;
                  end else begin
                     st_d = wcrc_pkg::LAT_IDLE;
                  end
               end
            end else if (beat_q == '0) begin
               // strobe tolerated within a window of cycles
               if (edge_win_q == 4'(wcrc_pkg::STROBE_WINDOW)) begin
                  st_d = wcrc_pkg::LAT_IDLE;
                  err_d = 1'b1;
               end else begin
                  edge_win_d = edge_win_q + 1'b1;
               end
            end
         end
         default: st_d = wcrc_pkg::LAT_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         st_q <= wcrc_pkg::LAT_IDLE;
         lat_q <= '0;
         need_q <= '0;
         beat_q <= '0;
         edge_win_q <= '0;
         crc_q <= '0;
         rx_crc_q <= '0;
         pend_q <= 1'b0;
         pend_a12_q <= 1'b0;
         pend_lat_q <= '0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         cur_bank_q <= '0;
      end else begin
         st_q <= st_d;
         lat_q <= lat_d;
         need_q <= need_d;
         beat_q <= beat_d;
         edge_win_q <= edge_win_d;
         crc_q <= crc_d;
         rx_crc_q <= rx_crc_d;
         pend_q <= pend_d;
         pend_a12_q <= pend_a12_d;
         pend_lat_q <= pend_lat_d;
         done_q <= done_d;
         err_q <= err_d;
         cur_bank_q <= cur_bank_d;
      end
   end

   assign BURST_DONE_O = done_q;
   assign CRC_ERR_O = err_q;

   // ------------------------------------------------------------
   // beat buffer: two entries; a beat arriving while both are full is dropped
   // ------------------------------------------------------------
   logic in_valid;
   logic [DQ_W+3:0] buf_out;
   logic buf_valid;
   assign in_valid = st_q == wcrc_pkg::LAT_BURST && dqs_edge && !crc_beat;

   wcrc_skid #(
      .W(DQ_W + 4),
      .DEPTH(2)
   ) u_buf (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .in_valid_i(in_valid),
      .in_ready_o(push_ok),
      .in_data_i({cur_bank_q, dq_s3_q}),
      .out_valid_o(buf_valid),
      .out_ready_i(BEAT_READY_I),
      .out_data_o(buf_out)
   );
   assign BEAT_VALID_O = buf_valid;
   assign BEAT_DATA_O = buf_out;

   // ------------------------------------------------------------
   // register port and status
   // ------------------------------------------------------------
   // long preamble with minimum latency is a bad setup
   assign cfg_bad = pre2 && cwl <= 5'(wcrc_pkg::CWL_FORBID);

   always_comb begin
      ctrl_d = ctrl_q;
      errcnt_d = errcnt_q;
      wrcnt_d = wrcnt_q;
      rdata_d = '0;
      tainted_d = tainted_q;
      if (err_q) begin
         tainted_d = 1'b1;
         errcnt_d = errcnt_q + 1'b1;
      end
      if (PRE_ALL_IDLE_I && !err_q) begin
         tainted_d = 1'b0;
      end
      if (done_q) begin
         wrcnt_d = wrcnt_q + 1'b1;
      end
      if (WR_I && ADDR_I == wcrc_pkg::REG_CTRL) begin
         ctrl_d = WDATA_I;
      end
      if (RD_I) begin
         unique case (ADDR_I)
            wcrc_pkg::REG_CTRL: rdata_d = ctrl_q;
            wcrc_pkg::REG_STATUS: rdata_d = {26'h0, dm_en && crc_en,
                                             tainted_q, cfg_bad,
                                             st_q == wcrc_pkg::LAT_IDLE,
                                             2'(st_q)};
            wcrc_pkg::REG_ERRCNT: rdata_d = {16'h0, errcnt_q};
            wcrc_pkg::REG_WRCNT: rdata_d = {16'h0, wrcnt_q};
            // strobe-fault tolerance only with crc and otf off
            wcrc_pkg::REG_ACCEPT: rdata_d = {31'h0, !crc_en &&
                                             burst_fld != wcrc_pkg::BURST_OTF};
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctrl_q <= wcrc_pkg::CTRL_RESET;
         errcnt_q <= '0;
         wrcnt_q <= '0;
         rdata_q <= '0;
         tainted_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         errcnt_q <= errcnt_d;
         wrcnt_q <= wrcnt_d;
         rdata_q <= rdata_d;
         tainted_q <= tainted_d;
      end
   end
   assign RDATA_O = rdata_q;
   // spacing is the controller's; BURST_DONE_O marks its start
endmodule : wcrc_write_path

/* File: sim/wcrc_write_path_props.sv */
`timescale 1ns/1ps
// --------------------
// link and port checks
// --------------------
module wcrc_write_path_props #(
   parameter int DQ_W = 8
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic WR_CMD_I,
   input wire logic PRE_ALL_IDLE_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic BEAT_VALID_O,
   input wire logic BEAT_READY_I,
   input wire logic [DQ_W+3:0] BEAT_DATA_O,
   input wire logic BURST_DONE_O,
   input wire logic CRC_ERR_O
);
   logic busy_q;
   logic busy_d;
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic st_rd;
   logic ct_rd;

   assign st_rd = RD_I && ADDR_I == wcrc_pkg::REG_STATUS;
   assign ct_rd = RD_I && ADDR_I == wcrc_pkg::REG_CTRL;

   always_comb begin
      busy_d = busy_q;
      ctrl_d = ctrl_q;
      if (BURST_DONE_O || CRC_ERR_O) busy_d = 1'h0;
      if (WR_CMD_I) busy_d = 1'h1;
      if (WR_I && ADDR_I == wcrc_pkg::REG_CTRL) ctrl_d = WDATA_I;
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         busy_q <= 1'h0;
         ctrl_q <= wcrc_pkg::CTRL_RESET;
      end else begin
         busy_q <= busy_d;
         ctrl_q <= ctrl_d;
      end
   end

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!NRST_I);

   property p_done_pulse;
      BURST_DONE_O |=> !BURST_DONE_O;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
   property p_err_in_burst;
      CRC_ERR_O |-> busy_q || $past(BURST_DONE_O) || $past(BURST_DONE_O, 2);
   endproperty
   a_err_in_burst: assert property (p_err_in_burst)
      else $error("error flag outside a burst");
   property p_hold;
      BEAT_VALID_O && !BEAT_READY_I |=>
         BEAT_VALID_O && $stable(BEAT_DATA_O);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stalled beat lost or changed");
   property p_quiet;
      WR_CMD_I && !busy_q |=> !BEAT_VALID_O [*8];
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("beat before write latency");
   property p_ctrl_rb;
      ct_rd |=> (RDATA_O & 32'h0000_1F1F) == (ctrl_q & 32'h0000_1F1F);
   endproperty
   a_ctrl_rb: assert property (p_ctrl_rb)
      else $error("control readback wrong");
   property p_cfg_bad;
      st_rd |=> RDATA_O[3] == (ctrl_q[3] && ctrl_q[12:8] <= 5'h09);
   endproperty
   a_cfg_bad: assert property (p_cfg_bad)
      else $error("latency flag wrong");
   property p_crc_dm;
      st_rd |=> RDATA_O[5] == (ctrl_q[2] && ctrl_q[4]);
   endproperty
   a_crc_dm: assert property (p_crc_dm)
      else $error("crc with mask flag wrong");
   property p_idle;
      st_rd && $past(PRE_ALL_IDLE_I) && !$past(CRC_ERR_O) |=>
         !RDATA_O[4];
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle flag wrong");
endmodule : wcrc_write_path_props

bind wcrc_write_path wcrc_write_path_props #(.DQ_W(DQ_W))
   wcrc_write_path_props_i (.CLK_I, .NRST_I, .WR_CMD_I, .PRE_ALL_IDLE_I,
   .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .BEAT_VALID_O, .BEAT_READY_I,
   .BEAT_DATA_O, .BURST_DONE_O, .CRC_ERR_O);

/* File: sim/ctrl_model.sv */
`timescale 1ns/1ps
// --------------------
// controller side model
// --------------------
module ctrl_model (
   input wire logic clk_i,
   output logic cmd_o,
   output logic a12_o,
   output logic dqs_o,
   output logic [7:0] dq_o
);
   initial begin
      cmd_o = 1'h0;
      a12_o = 1'h0;
      dqs_o = 1'h0;
      dq_o = 8'h00;
   end

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ({r[6:0], 1'h0} ^ 8'h07) : {r[6:0], 1'h0};
      end
      return r;
   endfunction

   // strobe stands low between bursts, so an even edge count is sent
   task automatic burst(input logic a12, input int cwl, input int n,
                        input logic crc, input logic bad,
                        input logic [7:0] base);
      logic [7:0] c;
      logic [7:0] v;
      c = 8'h00;
      @(posedge clk_i);
      cmd_o <= 1'h1;
      a12_o <= a12;
      @(posedge clk_i);
      cmd_o <= 1'h0;
      a12_o <= ~a12;
      repeat (cwl - 1) @(posedge clk_i);
      for (int i = 0; i < n + (crc ? 2 : 0); i++) begin
         v = base + 8'(i);
         if (i == n) v = bad ? ~c : c;
         if (i == n + 1) v = bad ? 8'h00 : 8'hFF;
         if (i < n) c = crc8(c, v);
         dq_o <= v;
         dqs_o <= ~dqs_o;
         repeat (4) @(posedge clk_i);
      end
      dq_o <= ~dq_o;
   endtask : burst
endmodule : ctrl_model

/* File: sim/wcrc_write_path_bench.sv */
`timescale 1ns/1ps
module wcrc_write_path_bench;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic cmd, a12, dqs, bvalid, done, cerr;
   logic [7:0] dq;
   logic [3:0] bank = 4'h3;
   logic pre_idle = 1'h0;
   logic ready = 1'h1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_s = 1'h0;
   logic rd_s = 1'h0;
   logic [31:0] rdata, rv;
   logic [11:0] bdata;
   logic [11:0] got[$];
   int done_n = 0;
   int err_n = 0;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;

   always #50 clk = ~clk;

   ctrl_model ctrl_model_i (.clk_i(clk), .cmd_o(cmd), .a12_o(a12),
      .dqs_o(dqs), .dq_o(dq));
   wcrc_write_path #(.DQ_W(8)) wcrc_write_path_i (.CLK_I(clk),
      .NRST_I(nrst), .WR_CMD_I(cmd), .A12_I(a12), .BANK_I(bank),
      .PRE_ALL_IDLE_I(pre_idle), .DQS_I(dqs), .DQ_I(dq), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
      .BEAT_VALID_O(bvalid), .BEAT_READY_I(ready), .BEAT_DATA_O(bdata),
      .BURST_DONE_O(done), .CRC_ERR_O(cerr));

   always @(posedge clk) begin
      cyc++;
      if (bvalid === 1'h1 && ready) got.push_back(bdata);
      if (done === 1'h1) done_n++;
      if (cerr === 1'h1) err_n++;
      if (cyc == 30000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk);
      rd_s <= 1'h0;
      @(negedge clk);
      rv = rdata;
   endtask : reg_rd

   // receiver stalls mid-burst; two entries must absorb it
   task automatic t_len(input logic [1:0] bf, input logic a, input int n);
      int d0;
      logic [7:0] b;
      logic [31:0] w0;
      b = 8'h40 + 8'(n) + {6'h00, bf};
      reg_wr(wcrc_pkg::REG_CTRL, 32'h0000_0904 | {30'h0, bf});
      reg_rd(wcrc_pkg::REG_WRCNT);
      w0 = rv;
      got.delete();
      d0 = done_n;
      fork
         ctrl_model_i.burst(a, 9, n, 1'h1, 1'h0, b);
         begin
            repeat (16) @(posedge clk);
            ready <= 1'h0;
            repeat (6) @(posedge clk);
            ready <= 1'h1;
         end
      join
      for (int i = 0; i < 40 && done_n == d0; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk(done_n - d0, 1);
      chk(got.size(), n);
      for (int i = 0; i < n; i++) chk(got[i], {bank, b + 8'(i)});
      reg_rd(wcrc_pkg::REG_WRCNT);
      chk(rv, w0 + 32'h0000_0001);
   endtask : t_len

   task automatic t_crc;
      logic [31:0] e;
      reg_wr(wcrc_pkg::REG_CTRL, 32'h0000_0904);
      reg_rd(wcrc_pkg::REG_ACCEPT);
      chk(rv, 32'h0000_0000);
      reg_rd(wcrc_pkg::REG_ERRCNT);
      e = rv;
      ctrl_model_i.burst(1'h0, 9, 8, 1'h1, 1'h1, 8'h10);
      repeat (12) @(posedge clk);
      reg_rd(wcrc_pkg::REG_ERRCNT);
      chk(rv, e + 32'h0000_0001);
   endtask : t_crc

   task automatic t_cfg;
      logic [31:0] cv[4] = '{32'h0000_0908, 32'h0000_0A08,
                             32'h0000_0914, 32'h0000_0904};
      logic [1:0] ev[4] = '{2'h1, 2'h0, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++) begin
         reg_wr(wcrc_pkg::REG_CTRL, cv[i]);
         reg_rd(wcrc_pkg::REG_STATUS);
         chk({rv[5], rv[3]}, ev[i]);
      end
   endtask : t_cfg

   task automatic t_strobe;
      int e0;
      reg_wr(wcrc_pkg::REG_CTRL, 32'h0000_0900);
      reg_rd(wcrc_pkg::REG_ACCEPT);
      chk(rv, 32'h0000_0001);
      e0 = err_n;
      ctrl_model_i.burst(1'h0, 9, 0, 1'h0, 1'h0, 8'h00);
      for (int i = 0; i < 30 && err_n == e0; i++) @(posedge clk);
      chk(err_n - e0, 1);
      reg_rd(wcrc_pkg::REG_STATUS);
      chk(rv[4], 1'h1);
      @(posedge clk);
      pre_idle <= 1'h1;
      repeat (8) @(posedge clk);
      reg_rd(wcrc_pkg::REG_STATUS);
      chk(rv[4], 1'h0);
      t_len(2'h0, 1'h1, 8);
      @(posedge clk);
      pre_idle <= 1'h0;
   endtask : t_strobe

   // full reset in mid-run brings ctrl and error count back
   task automatic t_reset;
      reg_wr(wcrc_pkg::REG_CTRL, 32'h0000_0A08);
      @(posedge clk);
      nrst <= 1'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      reg_rd(wcrc_pkg::REG_CTRL);
      chk(rv, wcrc_pkg::CTRL_RESET);
      reg_rd(wcrc_pkg::REG_ERRCNT);
      chk(rv, 32'h0000_0000);
   endtask : t_reset

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      reg_rd(wcrc_pkg::REG_CTRL);
      chk(rv, wcrc_pkg::CTRL_RESET);
      reg_wr(4'hF, 32'hFFFF_FFFF);
      reg_rd(4'hF);
      chk(rv, 32'h0000_0000);
      t_len(2'h0, 1'h0, 8);
      t_len(2'h1, 1'h1, 8);
      t_len(2'h1, 1'h0, 4);
      t_len(2'h2, 1'h1, 4);
      t_crc();
      t_cfg();
      t_strobe();
      t_reset();
      give_verdict();
   end
endmodule : wcrc_write_path_bench
